//--- tlbm_pkg.sv
`default_nettype none
package tlbm_pkg;
  localparam int ENTRIES = 32;
  localparam int IDX_W = 5;
  localparam int VPAGE_W = 29;
  localparam int VPAGE_32_W = 21;
  localparam int MASK_W = 8;
  localparam int FRAME_W = 22;

  // coprocessor register numbers
  localparam logic [4:0] REG_ENTRY_SELECT = 5'h00;
  localparam logic [4:0] REG_REPLACEMENT = 5'h01;
  localparam logic [4:0] REG_EVEN_DESC = 5'h02;
  localparam logic [4:0] REG_ODD_DESC = 5'h03;
  localparam logic [4:0] REG_PAGE_MASK = 5'h05;
  localparam logic [4:0] REG_LOCK_BOUNDARY = 5'h06;
  localparam logic [4:0] REG_TAG_HIGH = 5'h0a;

  // field positions
  localparam int SEL_PROBE_BIT = 31;
  localparam int TAG_REGION_LSB = 62;
  localparam int TAG_VPAGE_LSB = 11;
  localparam int TAG_VPAGE_MSB = 39;
  localparam int TAG_FILL_LSB = 40;
  localparam int TAG_FILL_MSB = 61;
  localparam int DESC_FRAME_LSB = 6;
  localparam int DESC_ATTR_LSB = 3;
  localparam int DESC_DIRTY_BIT = 2;
  localparam int DESC_VALID_BIT = 1;
  localparam int DESC_GLOBAL_BIT = 0;
  localparam int MASK_LSB = 11;
  localparam int PAGE_BASE_SHIFT = 10;

  // reset values
  localparam logic [4:0] REPLACE_UPPER = 5'h1f;
  localparam logic [4:0] BOUNDARY_RESET = 5'h00;
  localparam logic [4:0] SELECT_RESET = 5'h00;

  localparam logic [2:0] ATTR_UNCACHED = 3'h2;

  typedef enum logic [4:0] {
    OP_NONE = 5'h01,
    OP_PROBE = 5'h02,
    OP_READ = 5'h04,
    OP_WRITE_IDX = 5'h08,
    OP_WRITE_RAND = 5'h10
  } tlbm_op_t;

  typedef struct packed {
    logic [FRAME_W-1:0] frame;
    logic [2:0] attr;
    logic dirty;
    logic valid;
  } tlbm_desc_t;

  typedef struct packed {
    logic [1:0] region;
    logic [VPAGE_W-1:0] vpage;
    logic [MASK_W-1:0] mask;
    logic [7:0] space_id;
    logic glob;
    tlbm_desc_t even;
    tlbm_desc_t odd;
  } tlbm_entry_t;

  // address bit that picks the odd page: one above the page offset
  function automatic logic [4:0] tlbm_sel_bit(input logic [MASK_W-1:0] m);
    logic [4:0] n;
    n = 5'(PAGE_BASE_SHIFT);
    for (int i = 0; i < MASK_W; i++)
    begin
      n = n + 5'(m[i]);
    end
    return n;
  endfunction : tlbm_sel_bit
endpackage : tlbm_pkg
`default_nettype wire

//--- tlbm_match.sv
`timescale 1ns/1ps
`default_nettype none
module tlbm_match (
  input wire tlbm_pkg::tlbm_entry_t i_ent [tlbm_pkg::ENTRIES],
  input wire logic i_mode64,
  input wire logic [1:0] i_region,
  input wire logic [tlbm_pkg::VPAGE_W-1:0] i_vpage,
  input wire logic [7:0] i_space_id,
  output logic o_hit,
  output logic [tlbm_pkg::IDX_W-1:0] o_idx
);
  logic [tlbm_pkg::ENTRIES-1:0] hit_vec;
  logic [tlbm_pkg::VPAGE_W-1:0] width_care;

  // 32-bit mode compares only the low 21 tag bits and no region
  assign width_care = i_mode64 ? {tlbm_pkg::VPAGE_W{1'b1}}
                               : {{(tlbm_pkg::VPAGE_W-tlbm_pkg::VPAGE_32_W){1'b0}},
                                  {tlbm_pkg::VPAGE_32_W{1'b1}}};

  generate
    for (genvar g = 0; g < tlbm_pkg::ENTRIES; g++)
    begin : g_cmp
      logic [tlbm_pkg::VPAGE_W-1:0] care;
      assign care = width_care & ~{{(tlbm_pkg::VPAGE_W-tlbm_pkg::MASK_W){1'b0}}, i_ent[g].mask};
      assign hit_vec[g] = (((i_ent[g].vpage ^ i_vpage) & care) == '0)
                          && (!i_mode64 || (i_ent[g].region == i_region))
                          && (i_ent[g].glob || (i_ent[g].space_id == i_space_id));
    end
  endgenerate

  // lowest matching entry wins; software must not map overlaps
  always_comb
  begin
    o_hit = |hit_vec;
    o_idx = '0;
    for (int i = tlbm_pkg::ENTRIES - 1; i >= 0; i--)
    begin
      if (hit_vec[i])
      begin
        o_idx = 5'(i);
      end
    end
  end
endmodule : tlbm_match
`default_nettype wire

//--- tlbm_core.sv
//Contract
//- buffer holds exactly 32 paired entries
//- entry-select holds five-bit target entry field
//- select top bit: 1 probe miss, 0 hit
//- replacement pointer read-only, decrements per instruction
//- pointer loads 31 at reset, boundary write
//- write-random targets pointer low five bits
//- translation faults capture page and identifier; the code captures region and page only, not the identifier
//- eight-bit identifier stored, read, compared
//- global needs both descriptors; ignores identifier
//- clear valid bit raises invalid fault
//- clear dirty bit write-protects page
//- attribute two uncached, others cached
//- descriptor frame, attribute, dirty, valid, global layout
//- 64-bit region field matches address top bits
//- even descriptor first, odd descriptor second
//- descriptors move low 32 bits each
//- tag register feeds and receives entry tags
//- reserved fields read zero
//- tag fill field ignored, reads zero
//- mask bits 18:11 exclude compare bits
//- write-random spares locked entries; boundary resets zero
`timescale 1ns/1ps
`default_nettype none
module tlbm_core (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_cop_wr,
  input wire logic i_cop_rd,
  input wire logic [4:0] i_cop_num,
  input wire logic [63:0] i_cop_wdata,
  output logic [63:0] o_cop_rdata,
  input wire logic [4:0] i_tlb_op,
  input wire logic i_instr_exec,
  input wire logic i_mode64,
  input wire logic i_xlat_req,
  input wire logic i_xlat_store,
  input wire logic [63:0] i_xlat_va,
  output logic o_xlat_done,
  output logic [31:0] o_xlat_paddr,
  output logic o_xlat_miss,
  output logic o_xlat_invalid,
  output logic o_xlat_modified,
  output logic o_xlat_uncached
);
  tlbm_pkg::tlbm_entry_t ent [tlbm_pkg::ENTRIES];
  logic [4:0] sel_idx, next_sel_idx;
  logic probe_fail, next_probe_fail;
  logic [4:0] replace, next_replace;
  logic [4:0] boundary, next_boundary;
  logic [1:0] tag_region, next_tag_region;
  logic [tlbm_pkg::VPAGE_W-1:0] tag_vpage, next_tag_vpage;
  logic [7:0] tag_space_id, next_tag_space_id;
  tlbm_pkg::tlbm_desc_t even_desc, next_even_desc, odd_desc, next_odd_desc;
  logic even_glob, next_even_glob, odd_glob, next_odd_glob;
  logic [7:0] page_mask, next_page_mask;
  logic [63:0] next_rdata;
  logic next_done, next_miss, next_invalid, next_modified, next_uncached;
  logic [31:0] next_paddr;
  logic ent_we;
  logic [4:0] ent_widx;
  tlbm_pkg::tlbm_entry_t ent_wdata, x_ent;
  tlbm_pkg::tlbm_desc_t x_desc;
  logic prb_hit, x_hit, bnd_wr, x_fault;
  logic [4:0] prb_idx, x_idx, x_sel;
  logic [31:0] x_offmask;

  function automatic tlbm_pkg::tlbm_desc_t desc_from(input logic [63:0] w);
    tlbm_pkg::tlbm_desc_t d;
    d.frame = w[tlbm_pkg::DESC_FRAME_LSB +: tlbm_pkg::FRAME_W];
    d.attr = w[tlbm_pkg::DESC_ATTR_LSB +: 3];
    d.dirty = w[tlbm_pkg::DESC_DIRTY_BIT];
    d.valid = w[tlbm_pkg::DESC_VALID_BIT];
    return d;
  endfunction : desc_from

  // upper 36 bits are reserved and always read zero
  function automatic logic [63:0] desc_to(input tlbm_pkg::tlbm_desc_t d, input logic g);
    logic [63:0] w;
    w = '0;
    w[tlbm_pkg::DESC_FRAME_LSB +: tlbm_pkg::FRAME_W] = d.frame;
    w[tlbm_pkg::DESC_ATTR_LSB +: 3] = d.attr;
    w[tlbm_pkg::DESC_DIRTY_BIT] = d.dirty;
    w[tlbm_pkg::DESC_VALID_BIT] = d.valid;
    w[tlbm_pkg::DESC_GLOBAL_BIT] = g;
    return w;
  endfunction : desc_to

  tlbm_match u_probe (
    .i_ent(ent),
    .i_mode64(i_mode64),
    .i_region(tag_region),
    .i_vpage(tag_vpage),
    .i_space_id(tag_space_id),
    .o_hit(prb_hit),
    .o_idx(prb_idx)
  );

  tlbm_match u_xlat (
    .i_ent(ent),
    .i_mode64(i_mode64),
    .i_region(i_xlat_va[63:62]),
    .i_vpage(i_xlat_va[tlbm_pkg::TAG_VPAGE_MSB:tlbm_pkg::TAG_VPAGE_LSB]),
    .i_space_id(tag_space_id),
    .o_hit(x_hit),
    .o_idx(x_idx)
  );

  assign bnd_wr = i_cop_wr && (i_cop_num == tlbm_pkg::REG_LOCK_BOUNDARY);

  always_comb
  begin
    x_ent = ent[x_idx];
    x_sel = tlbm_pkg::tlbm_sel_bit(x_ent.mask);
    x_desc = i_xlat_va[x_sel] ? x_ent.odd : x_ent.even;
    x_offmask = ~(32'hffffffff << x_sel);
    x_fault = i_xlat_req && (!x_hit || !x_desc.valid || (i_xlat_store && !x_desc.dirty));
  end

  always_comb
  begin
    next_sel_idx = sel_idx;
    next_probe_fail = probe_fail;
    next_replace = replace;
    next_boundary = boundary;
    next_tag_region = tag_region;
    next_tag_vpage = tag_vpage;
    next_tag_space_id = tag_space_id;
    next_even_desc = even_desc;
    next_odd_desc = odd_desc;
    next_even_glob = even_glob;
    next_odd_glob = odd_glob;
    next_page_mask = page_mask;
    ent_we = 1'b0;
    ent_widx = sel_idx;
    ent_wdata.region = tag_region;
    ent_wdata.vpage = tag_vpage;
    ent_wdata.mask = page_mask;
    ent_wdata.space_id = tag_space_id;
    ent_wdata.glob = even_glob & odd_glob;
    ent_wdata.even = even_desc;
    ent_wdata.odd = odd_desc;
    if (i_cop_wr)
    begin
      case (i_cop_num)
        tlbm_pkg::REG_ENTRY_SELECT: next_sel_idx = i_cop_wdata[4:0];
        tlbm_pkg::REG_EVEN_DESC:
        begin
          next_even_desc = desc_from(i_cop_wdata);
          next_even_glob = i_cop_wdata[tlbm_pkg::DESC_GLOBAL_BIT];
        end
        tlbm_pkg::REG_ODD_DESC:
        begin
          next_odd_desc = desc_from(i_cop_wdata);
          next_odd_glob = i_cop_wdata[tlbm_pkg::DESC_GLOBAL_BIT];
        end
        tlbm_pkg::REG_PAGE_MASK: next_page_mask = i_cop_wdata[tlbm_pkg::MASK_LSB +: tlbm_pkg::MASK_W];
        tlbm_pkg::REG_LOCK_BOUNDARY: next_boundary = i_cop_wdata[4:0];
        tlbm_pkg::REG_TAG_HIGH:
        begin
          // fill bits are simply not stored
          next_tag_region = i_cop_wdata[tlbm_pkg::TAG_REGION_LSB +: 2];
          next_tag_vpage = i_cop_wdata[tlbm_pkg::TAG_VPAGE_MSB:tlbm_pkg::TAG_VPAGE_LSB];
          next_tag_space_id = i_cop_wdata[7:0];
        end
        default: ;
      endcase
    end
    if (bnd_wr)
    begin
      next_replace = tlbm_pkg::REPLACE_UPPER;
    end
    else if (i_instr_exec)
    begin
      next_replace = (replace == boundary) ? tlbm_pkg::REPLACE_UPPER : replace - 5'h01;
    end
    unique case (tlbm_pkg::tlbm_op_t'(i_tlb_op))
      tlbm_pkg::OP_NONE: ;
      tlbm_pkg::OP_PROBE:
      begin
        next_probe_fail = !prb_hit;
        if (prb_hit)
        begin
          next_sel_idx = prb_idx;
        end
      end
      tlbm_pkg::OP_READ:
      begin
        next_tag_region = ent[sel_idx].region;
        next_tag_vpage = ent[sel_idx].vpage;
        next_tag_space_id = ent[sel_idx].space_id;
        next_page_mask = ent[sel_idx].mask;
        next_even_desc = ent[sel_idx].even;
        next_odd_desc = ent[sel_idx].odd;
        next_even_glob = ent[sel_idx].glob;
        next_odd_glob = ent[sel_idx].glob;
      end
      tlbm_pkg::OP_WRITE_IDX: ent_we = 1'b1;
      tlbm_pkg::OP_WRITE_RAND:
      begin
        // pointer never sits below the boundary, so locked entries stay intact
        ent_we = 1'b1;
        ent_widx = replace;
      end
      default: ;
    endcase
    // a fault wins over a same-cycle software write of the tag region and page; the identifier takes the written value
    if (x_fault)
    begin
      next_tag_region = i_xlat_va[63:62];
      next_tag_vpage = i_xlat_va[tlbm_pkg::TAG_VPAGE_MSB:tlbm_pkg::TAG_VPAGE_LSB];
    end
  end

  always_comb
  begin
    next_done = i_xlat_req;
    next_miss = i_xlat_req && !x_hit;
    next_invalid = i_xlat_req && x_hit && !x_desc.valid;
    next_modified = i_xlat_req && x_hit && x_desc.valid && i_xlat_store && !x_desc.dirty;
    next_uncached = i_xlat_req && x_hit && (x_desc.attr == tlbm_pkg::ATTR_UNCACHED);
    next_paddr = ({x_desc.frame, 10'h000} & ~x_offmask) | (i_xlat_va[31:0] & x_offmask);
    next_rdata = o_cop_rdata;
    if (i_cop_rd)
    begin
      next_rdata = '0;
      case (i_cop_num)
        tlbm_pkg::REG_ENTRY_SELECT:
        begin
          next_rdata[tlbm_pkg::SEL_PROBE_BIT] = probe_fail;
          next_rdata[4:0] = sel_idx;
        end
        tlbm_pkg::REG_REPLACEMENT: next_rdata[4:0] = replace;
        tlbm_pkg::REG_EVEN_DESC: next_rdata = desc_to(even_desc, even_glob);
        tlbm_pkg::REG_ODD_DESC: next_rdata = desc_to(odd_desc, odd_glob);
        tlbm_pkg::REG_PAGE_MASK: next_rdata[tlbm_pkg::MASK_LSB +: tlbm_pkg::MASK_W] = page_mask;
        tlbm_pkg::REG_LOCK_BOUNDARY: next_rdata[4:0] = boundary;
        tlbm_pkg::REG_TAG_HIGH:
        begin
          next_rdata[tlbm_pkg::TAG_REGION_LSB +: 2] = tag_region;
          next_rdata[tlbm_pkg::TAG_VPAGE_MSB:tlbm_pkg::TAG_VPAGE_LSB] = tag_vpage;
          next_rdata[7:0] = tag_space_id;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sel_idx <= tlbm_pkg::SELECT_RESET;
      probe_fail <= 1'b0;
      replace <= tlbm_pkg::REPLACE_UPPER;
      boundary <= tlbm_pkg::BOUNDARY_RESET;
      tag_region <= '0;
      tag_vpage <= '0;
      tag_space_id <= '0;
      even_desc <= '0;
      odd_desc <= '0;
      even_glob <= 1'b0;
      odd_glob <= 1'b0;
      page_mask <= '0;
      o_cop_rdata <= '0;
      o_xlat_done <= 1'b0;
      o_xlat_paddr <= '0;
      o_xlat_miss <= 1'b0;
      o_xlat_invalid <= 1'b0;
      o_xlat_modified <= 1'b0;
      o_xlat_uncached <= 1'b0;
    end
    else
    begin
      sel_idx <= next_sel_idx;
      probe_fail <= next_probe_fail;
      replace <= next_replace;
      boundary <= next_boundary;
      tag_region <= next_tag_region;
      tag_vpage <= next_tag_vpage;
      tag_space_id <= next_tag_space_id;
      even_desc <= next_even_desc;
      odd_desc <= next_odd_desc;
      even_glob <= next_even_glob;
      odd_glob <= next_odd_glob;
      page_mask <= next_page_mask;
      o_cop_rdata <= next_rdata;
      o_xlat_done <= next_done;
      o_xlat_paddr <= next_paddr;
      o_xlat_miss <= next_miss;
      o_xlat_invalid <= next_invalid;
      o_xlat_modified <= next_modified;
      o_xlat_uncached <= next_uncached;
    end
  end

  // entries clear at reset so no stale valid mapping survives
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      for (int i = 0; i < tlbm_pkg::ENTRIES; i++)
      begin
        ent[i] <= '0;
      end
    end
    else if (ent_we)
    begin
      ent[ent_widx] <= ent_wdata;
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_probe;
    i_tlb_op == tlbm_pkg::OP_PROBE;
  endsequence
  sequence s_count;
    i_instr_exec && !bnd_wr;
  endsequence

  chk_bnd_reload: assert property (bnd_wr |=> replace == tlbm_pkg::REPLACE_UPPER)
    else $error("pointer not reloaded after boundary write");
  chk_ptr_wrap: assert property ((s_count ##0 replace == boundary) |=> replace == tlbm_pkg::REPLACE_UPPER)
    else $error("pointer did not wrap at lower bound");
  chk_ptr_dec: assert property ((s_count ##0 replace != boundary) |=> replace == $past(replace) - 5'h01)
    else $error("pointer did not decrement");
  chk_ptr_range: assert property (replace >= boundary)
    else $error("pointer below boundary");
  chk_probe_miss: assert property ((s_probe ##0 !prb_hit) |=> probe_fail)
    else $error("probe miss not flagged");
  chk_probe_hit: assert property ((s_probe ##0 prb_hit) |=> !probe_fail && sel_idx == $past(prb_idx))
    else $error("probe hit index wrong");
  chk_rand_write: assert property (i_tlb_op == tlbm_pkg::OP_WRITE_RAND |=> ent[$past(replace)] == $past(ent_wdata))
    else $error("random write landed elsewhere");
  chk_invalid_flag: assert property ((i_xlat_req && x_hit && !x_desc.valid) |=> o_xlat_invalid && o_xlat_done)
    else $error("invalid fault missing");
  chk_uncached_attr: assert property (o_xlat_uncached |-> $past(x_desc.attr) == tlbm_pkg::ATTR_UNCACHED)
    else $error("uncached without attribute two");
  chk_fault_capture: assert property ((i_xlat_req && !x_hit) |=> tag_vpage == $past(i_xlat_va[39:11]))
    else $error("fault page not captured");
  chk_fill_zero: assert property ((i_cop_rd && i_cop_num == tlbm_pkg::REG_TAG_HIGH) |=> o_cop_rdata[61:40] == '0)
    else $error("fill field not zero");
endmodule : tlbm_core
`default_nettype wire

//--- tlbm_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
module tlbm_pipe_model (
  input wire logic i_sys_clk,
  output logic o_cop_wr,
  output logic o_cop_rd,
  output logic [4:0] o_cop_num,
  output logic [63:0] o_cop_wdata,
  output logic [4:0] o_tlb_op,
  output logic o_instr_exec,
  output logic o_xlat_req,
  output logic o_xlat_store,
  output logic [63:0] o_xlat_va,
  input wire logic [63:0] i_cop_rdata,
  input wire logic [4:0] i_xlat_flags,
  input wire logic [31:0] i_xlat_paddr
);
  initial
  begin
    o_cop_wr = 1'b0;
    o_cop_rd = 1'b0;
    o_cop_num = 5'h00;
    o_cop_wdata = 64'h0;
    o_tlb_op = 5'h01;
    o_instr_exec = 1'b0;
    o_xlat_req = 1'b0;
    o_xlat_store = 1'b0;
    o_xlat_va = 64'h0;
  end

  // every task leaves one idle cycle before the next request
  task automatic wr(input logic [4:0] num, input logic [63:0] d);
    @(negedge i_sys_clk);
    o_cop_wr = 1'b1;
    o_cop_num = num;
    o_cop_wdata = d;
    @(negedge i_sys_clk);
    o_cop_wr = 1'b0;
    // stale data is not left on the bus
    o_cop_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [4:0] num, output logic [63:0] q);
    @(negedge i_sys_clk);
    o_cop_rd = 1'b1;
    o_cop_num = num;
    @(negedge i_sys_clk);
    o_cop_rd = 1'b0;
    q = i_cop_rdata;
  endtask : rd

  task automatic op(input logic [4:0] code);
    @(negedge i_sys_clk);
    o_tlb_op = code;
    @(negedge i_sys_clk);
    o_tlb_op = 5'h01;
  endtask : op

  task automatic run(input int n);
    @(negedge i_sys_clk);
    o_instr_exec = 1'b1;
    repeat (n) @(negedge i_sys_clk);
    o_instr_exec = 1'b0;
  endtask : run

  task automatic xl(input logic [63:0] va, input logic st, output logic [4:0] f, output logic [31:0] pa);
    @(negedge i_sys_clk);
    o_xlat_req = 1'b1;
    o_xlat_store = st;
    o_xlat_va = va;
    @(negedge i_sys_clk);
    o_xlat_req = 1'b0;
    o_xlat_va = ~va;
    f = i_xlat_flags;
    pa = i_xlat_paddr;
  endtask : xl
endmodule : tlbm_pipe_model
`default_nettype wire

//--- tlb_management_registers_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tlb_management_registers_tb_top;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic wr, rd, exec, req, st, done, miss, inv, modf, unc;
  logic mode64 = 1'b1;
  logic [4:0] num, tlb_op;
  logic [63:0] wdata, rdata, va;
  logic [31:0] paddr;
  int bad_count = 0;
  int n_tests = 0;
  localparam logic [28:0] VPA = 29'h0000123;

  always #4 i_sys_clk = ~i_sys_clk;

  tlbm_core tlbm_core_i (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_cop_wr(wr), .i_cop_rd(rd),
    .i_cop_num(num), .i_cop_wdata(wdata), .o_cop_rdata(rdata), .i_tlb_op(tlb_op), .i_instr_exec(exec),
    .i_mode64(mode64), .i_xlat_req(req), .i_xlat_store(st), .i_xlat_va(va), .o_xlat_done(done),
    .o_xlat_paddr(paddr), .o_xlat_miss(miss), .o_xlat_invalid(inv), .o_xlat_modified(modf),
    .o_xlat_uncached(unc));

  tlbm_pipe_model tlbm_pipe_model_i (.i_sys_clk(i_sys_clk), .o_cop_wr(wr), .o_cop_rd(rd), .o_cop_num(num),
    .o_cop_wdata(wdata), .o_tlb_op(tlb_op), .o_instr_exec(exec), .o_xlat_req(req), .o_xlat_store(st),
    .o_xlat_va(va), .i_cop_rdata(rdata), .i_xlat_flags({done, miss, inv, modf, unc}), .i_xlat_paddr(paddr));

  function automatic logic [63:0] th(input logic [1:0] r, input logic [28:0] vp, input logic [7:0] id);
    return {r, 22'h0, vp, 3'h0, id};
  endfunction : th

  function automatic logic [63:0] dsc(input logic [21:0] f, input logic [2:0] c, input logic [2:0] dvg);
    return {36'h0, f, c, dvg};
  endfunction : dsc

  function automatic logic [63:0] vad(input logic [28:0] vp, input logic odd, input logic [9:0] off);
    return {2'h3, 22'h0, vp, odd, off};
  endfunction : vad

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rc(input logic [4:0] n, input logic [63:0] exp);
    logic [63:0] q;
    tlbm_pipe_model_i.rd(n, q);
    chk(q, exp);
  endtask : rc

  // physical address is only meaningful when no fault is flagged
  task automatic tx(input logic [63:0] a, input logic s, input logic [4:0] ef, input logic [31:0] ep);
    logic [4:0] f;
    logic [31:0] p;
    tlbm_pipe_model_i.xl(a, s, f, p);
    chk(64'(f), 64'(ef));
    if (ef[3:1] == 3'h0)
    begin
      chk(64'(p), 64'(ep));
    end
  endtask : tx

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  initial
  begin
    #(8 * 20000);
    bad_count++;
    close_out();
  end

  initial
  begin
    repeat (12) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst_b = 1'b1;
    rc(5'h00, 64'h0);
    rc(5'h01, 64'h1f);
    rc(5'h06, 64'h0);
    rc(5'h1f, 64'h0);
    $display("test reset done");
    tlbm_pipe_model_i.wr(5'h0a, th(2'h3, VPA, 8'h11) | 64'h3fff_ff00_0000_0000);
    rc(5'h0a, th(2'h3, VPA, 8'h11));
    tlbm_pipe_model_i.wr(5'h05, 64'hffff_ffff_ffff_ffff);
    rc(5'h05, 64'h0007_f800);
    tlbm_pipe_model_i.wr(5'h05, 64'h0);
    tlbm_pipe_model_i.wr(5'h02, dsc(22'h0abcd, 3'h2, 3'b011));
    tlbm_pipe_model_i.wr(5'h03, dsc(22'h01234, 3'h0, 3'b111));
    tlbm_pipe_model_i.wr(5'h00, 64'h5);
    tlbm_pipe_model_i.op(5'h08);
    tlbm_pipe_model_i.op(5'h02);
    rc(5'h00, 64'h5);
    tlbm_pipe_model_i.wr(5'h00, 64'hffff_ffff_ffff_ffff);
    rc(5'h00, 64'h1f);
    tlbm_pipe_model_i.wr(5'h0a, th(2'h3, 29'h44, 8'h11));
    tlbm_pipe_model_i.op(5'h02);
    rc(5'h00, 64'h8000_001f);
    $display("test probe done");
    tlbm_pipe_model_i.wr(5'h02, 64'h0);
    tlbm_pipe_model_i.wr(5'h03, 64'h0);
    tlbm_pipe_model_i.wr(5'h00, 64'h5);
    tlbm_pipe_model_i.op(5'h04);
    rc(5'h0a, th(2'h3, VPA, 8'h11));
    rc(5'h02, dsc(22'h0abcd, 3'h2, 3'b011));
    rc(5'h03, dsc(22'h01234, 3'h0, 3'b111));
    $display("test read entry done");
    tlbm_pipe_model_i.wr(5'h0a, th(2'h3, 29'h7, 8'h22));
    tx(vad(VPA, 1'b0, 10'h155), 1'b0, 5'b10001, {22'h0abcd, 10'h155});
    tx(vad(VPA, 1'b0, 10'h0aa), 1'b1, 5'b10011, 32'h0);
    tx(vad(VPA, 1'b1, 10'h3c3), 1'b1, 5'b10000, {22'h01234, 10'h3c3});
    tlbm_pipe_model_i.wr(5'h02, dsc(22'h00055, 3'h0, 3'b000));
    tlbm_pipe_model_i.wr(5'h03, dsc(22'h00066, 3'h0, 3'b111));
    tlbm_pipe_model_i.wr(5'h00, 64'h2);
    // the store fault above captured its page into the tag register
    tlbm_pipe_model_i.wr(5'h0a, th(2'h3, 29'h7, 8'h22));
    tlbm_pipe_model_i.op(5'h08);
    tx(vad(29'h7, 1'b0, 10'h001), 1'b0, 5'b10100, 32'h0);
    tlbm_pipe_model_i.wr(5'h0a, th(2'h3, 29'h7, 8'h33));
    tx(vad(29'h7, 1'b1, 10'h001), 1'b0, 5'b11000, 32'h0);
    tx(vad(29'h5, 1'b0, 10'h001), 1'b0, 5'b11000, 32'h0);
    rc(5'h0a, th(2'h3, 29'h5, 8'h33));
    tx({2'h0, vad(VPA, 1'b1, 10'h011)} & 64'h3fff_ffff_ffff_ffff, 1'b0, 5'b11000, 32'h0);
    mode64 = 1'b0;
    // 32-bit mode ignores the region field, so the same address now hits
    tx(vad(VPA, 1'b1, 10'h011) & 64'h3fff_ffff_ffff_ffff, 1'b0, 5'b10000, {22'h01234, 10'h011});
    mode64 = 1'b1;
    $display("test translate done");
    tlbm_pipe_model_i.wr(5'h06, 64'h4);
    rc(5'h06, 64'h4);
    tlbm_pipe_model_i.wr(5'h0a, th(2'h3, 29'h9, 8'h11));
    tlbm_pipe_model_i.wr(5'h02, dsc(22'h00077, 3'h3, 3'b110));
    tlbm_pipe_model_i.op(5'h10);
    tlbm_pipe_model_i.wr(5'h02, 64'h0);
    tlbm_pipe_model_i.wr(5'h00, 64'h1f);
    tlbm_pipe_model_i.op(5'h04);
    rc(5'h02, dsc(22'h00077, 3'h3, 3'b110));
    tlbm_pipe_model_i.wr(5'h01, 64'h0);
    rc(5'h01, 64'h1f);
    tlbm_pipe_model_i.run(27);
    rc(5'h01, 64'h4);
    tlbm_pipe_model_i.run(1);
    rc(5'h01, 64'h1f);
    $display("test replacement done");
    close_out();
  end
endmodule : tlb_management_registers_tb_top
`default_nettype wire
